// file: shared/policy_pkg.sv
// Constants, types and helpers for the reset, panel-loss and stop policy.
// Assumes one 200 MHz clock and a plain byte-wide register port.
// Behaviour
// - Policy accepts 0-3, 14-17; default 14
// - Odd policies: line reset only while tripped
// - Reset while running coasts, clears overload values
// - Panel reset key works only while tripped
// - Loss policies: panel absent over 1s alarms
// - Continue policies: panel loss raises no alarm
// - Panel absent since power-on never alarms
// - Jog with continue policy decelerates on loss
// - Serial link on panel port disables loss
// - Policies 14-17: stop key everywhere, external holds
// - Policies 0-3: no hold, panel-mode stop only
// - Hold refuses restart until its booked source or a line reset clears
// - External panel stop always decelerates, never coasts
// - Non-source panel stop in panel mode holds
// - Automatic source selection prefers the unit
// - Policy writable anytime, survives parameter clear
// - Serial panel mode: built-in stop decelerates
package policy_pkg;

    // Register offsets on the byte port
    localparam logic [3:0] OFS_POLICY = 4'h0;
    localparam logic [3:0] OFS_CTRL = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;

    // Policy value ranges and reset value
    localparam logic [4:0] POLICY_RESET = 5'h0E;
    localparam logic [4:0] POLICY_STD_TOP = 5'h03;
    localparam logic [4:0] POLICY_ALT_BASE = 5'h0E;
    localparam logic [4:0] POLICY_ALT_TOP = 5'h11;

    // Decoded policy selection bits
    localparam int SEL_TRIP_ONLY = 0;
    localparam int SEL_LOSS = 1;

    // Control register fields
    localparam int CTRL_COAST = 0;
    localparam int CTRL_SRC_AUTO = 1;
    localparam int CTRL_SRC_UNIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h02;

    // Panel-loss time and clock rate
    localparam int unsigned LOSS_TIME_MS = 1000;
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned LOSS_CYCLES = LOSS_TIME_MS * CLK_KHZ;

    // Operation mode reported by the core
    typedef enum logic [1:0] {MODE_PANEL, MODE_EXT, MODE_NET} op_mode_t;

    // Hold state and whose path clears it
    typedef enum logic [1:0] {HOLD_NONE, HOLD_PANEL, HOLD_UNIT} hold_t;

    // Pin inputs, all asynchronous to clk
    typedef struct packed {
        logic external_reset_input;
        logic forward_start_input;
        logic reverse_start_input;
        logic unit_present;
        logic panel_stop_key;
        logic panel_reset_key;
        logic unit_stop_key;
        logic unit_reset_key;
        logic external_mode_key;
    } pin_in_t;

    // Status from the drive core, same clock
    typedef struct packed {
        logic running;
        logic tripped;
        logic jog_active;
        logic serial_on_panel_port;
        logic comm_reset;
        op_mode_t mode;
    } core_state_t;

    // Commands back to the drive core
    typedef struct packed {
        logic output_shutoff;
        logic decel_stop;
        logic panel_loss_alarm;
        logic panel_stop_hold;
        logic overload_clear;
        logic reset_done;
        logic start_inhibit;
    } policy_out_t;

    // Policy value lies in an accepted range
    function automatic logic policy_legal(input logic [4:0] v);
        return (v <= POLICY_STD_TOP) ||
            (v >= POLICY_ALT_BASE && v <= POLICY_ALT_TOP);
    endfunction

    // Fold 14-17 onto 0-3 selection bits
    function automatic logic [1:0] policy_sel(input logic [4:0] v);
        logic [4:0] d;
        d = (v >= POLICY_ALT_BASE) ? v - POLICY_ALT_BASE : v;
        return d[1:0];
    endfunction

endpackage

// file: rtl/sync2.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second
    logic [W-1:0] meta_reg;

    // Two stages, constants under reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

// file: rtl/loss_timer.sv
// Panel-loss timer: arms once the panel is seen, then times absence.
// Assumes present is already synchronised to clk.
`timescale 1ns/1ps
module loss_timer #(
    parameter int unsigned LIMIT = policy_pkg::LOSS_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic present,
    input wire logic enable,
    output logic lost
);

    logic armed_reg; // Panel seen since power-on
    logic armed_next;
    logic [31:0] cnt_reg; // Absence cycles
    logic [31:0] cnt_next;
    logic lost_next;

    // Next counter and flag values
    always_comb begin
        armed_next = armed_reg | present;
        cnt_next = cnt_reg;
        if (present || !enable || !armed_reg) begin
            cnt_next = '0;
        end else if (cnt_reg <= LIMIT) begin
            cnt_next = cnt_reg + 32'h1;
        end
        lost_next = (cnt_next > LIMIT);
    end

    // Register stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_reg <= 1'b0;
            cnt_reg <= '0;
            lost <= 1'b0;
        end else begin
            armed_reg <= armed_next;
            cnt_reg <= cnt_next;
            lost <= lost_next;
        end
    end

endmodule

// file: rtl/reset_panel_loss_stop_policy.sv
// Reset acceptance, panel-loss alarm and panel stop hold policy.
// Assumes core status on clk; keys and terminals arrive as raw pins.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module reset_panel_loss_stop_policy #(
    parameter int unsigned LOSS_LIMIT = policy_pkg::LOSS_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire policy_pkg::pin_in_t pins,
    input wire policy_pkg::core_state_t core,
    output policy_pkg::policy_out_t outs
);
    import policy_pkg::*;

    // Synchronised pins and their previous sample
    pin_in_t ps;
    pin_in_t pp_reg;
    pin_in_t rise;
    pin_in_t fall;

    // Software registers
    logic [4:0] policy_reg; // Policy value
    logic [4:0] policy_next;
    logic [7:0] ctrl_reg; // Source and stop-method control
    logic [7:0] ctrl_next;
    logic [7:0] rdata_next;

    // Policy state
    hold_t hold_reg;
    hold_t hold_next;
    op_mode_t mode_reg; // Previous core mode
    logic alarm_reg;
    logic alarm_next;
    policy_out_t outs_next;

    // Decoded policy and events
    logic [1:0] sel;
    logic trip_only;
    logic loss_sel;
    logic stop_any;
    logic line_rst;
    logic key_rst;
    logic reset_acc;
    logic detect_en;
    logic lost;
    logic unit_src;
    logic pstop;
    logic ustop;
    logic src_stop;
    logic other_stop;
    logic starts_off;
    logic decel;
    logic hold_set;
    hold_t hold_who;

    // Pin synchroniser
    sync2 #(
        .W($bits(pin_in_t))
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(pins),
        .q(ps)
    );

    // Absence timer
    loss_timer #(
        .LIMIT(LOSS_LIMIT)
    ) u_loss (
        .clk(clk),
        .arst_n(arst_n),
        .present(ps.unit_present),
        .enable(detect_en),
        .lost(lost)
    );

    // Edges, policy decode and stop sources
    always_comb begin
        rise = pin_in_t'(ps & ~pp_reg);
        fall = pin_in_t'(~ps & pp_reg);
        sel = policy_sel(policy_reg);
        trip_only = sel[SEL_TRIP_ONLY];
        loss_sel = sel[SEL_LOSS];
        stop_any = (policy_reg >= POLICY_ALT_BASE);
        // Line reset from terminal or communication
        line_rst = rise.external_reset_input | core.comm_reset;
        key_rst = rise.panel_reset_key | rise.unit_reset_key;
        reset_acc = (line_rst & (~trip_only | core.tripped))
            | (key_rst & core.tripped);
        // Serial link on the panel port masks loss detection
        detect_en = loss_sel & ~core.serial_on_panel_port;
        // Automatic selection lets a present unit win
        if (ctrl_reg[CTRL_SRC_AUTO]) begin
            unit_src = ps.unit_present;
        end else begin
            unit_src = ctrl_reg[CTRL_SRC_UNIT];
        end
        pstop = rise.panel_stop_key;
        ustop = rise.unit_stop_key & ps.unit_present;
        src_stop = unit_src ? ustop : pstop;
        other_stop = unit_src ? pstop : ustop;
        starts_off = ~ps.forward_start_input & ~ps.reverse_start_input;
    end

    // Stop decisions
    always_comb begin
        decel = 1'b0;
        hold_set = 1'b0;
        hold_who = HOLD_NONE;
        if (core.mode == MODE_PANEL) begin
            // Any panel stop decelerates in panel mode
            decel = src_stop | other_stop;
            if (other_stop && stop_any) begin
                // Booked to the selected source, panel or unit, whose path clears it
                hold_set = 1'b1;
                hold_who = unit_src ? HOLD_UNIT : HOLD_PANEL;
            end
        end else if (stop_any && (pstop || ustop)) begin
            // Decelerate even when coasting is selected
            decel = 1'b1;
            if (core.mode == MODE_EXT) begin
                hold_set = 1'b1;
                hold_who = ustop ? HOLD_UNIT : HOLD_PANEL;
            end
        end
        // Jog under a continue policy stops when the panel leaves
        if (core.jog_active && !loss_sel && fall.unit_present) begin
            decel = 1'b1;
        end
    end

    // Hold state machine
    always_comb begin
        hold_next = hold_reg;
        case (hold_reg)
            HOLD_NONE: begin
                hold_next = HOLD_NONE;
            end
            HOLD_PANEL: begin
                // Entering panel mode with starts off clears it
                if (core.mode == MODE_PANEL && mode_reg != MODE_PANEL
                    && starts_off) begin
                    hold_next = HOLD_NONE;
                end
            end
            HOLD_UNIT: begin
                // External key or entering external mode clears it
                if ((rise.external_mode_key && starts_off) ||
                    (core.mode == MODE_EXT && mode_reg != MODE_EXT)) begin
                    hold_next = HOLD_NONE;
                end
            end
            default: begin
                hold_next = HOLD_NONE;
            end
        endcase
        if (reset_acc && line_rst) begin
            hold_next = HOLD_NONE;
        end
        // A new stop wins over any clear
        if (hold_set) begin
            hold_next = hold_who;
        end
    end

    // Alarm and outputs
    always_comb begin
        // Latched loss, set wins over reset clear
        alarm_next = (lost & detect_en)
            | (alarm_reg & ~reset_acc);
        outs_next.panel_loss_alarm = alarm_next;
        outs_next.output_shutoff = alarm_next
            | (reset_acc & core.running);
        outs_next.overload_clear = reset_acc;
        outs_next.reset_done = reset_acc;
        outs_next.decel_stop = decel;
        outs_next.panel_stop_hold = (hold_next != HOLD_NONE);
        outs_next.start_inhibit = (hold_next != HOLD_NONE)
            | alarm_next;
    end

    // Register port: writes and one-cycle read data
    always_comb begin
        policy_next = policy_reg;
        ctrl_next = ctrl_reg;
        rdata_next = 8'h00;
        if (wr) begin
            // Policy writable at any time; only legal values stick
            if (addr == OFS_POLICY && policy_legal(wdata[4:0])
                && wdata[7:5] == 3'h0) begin
                policy_next = wdata[4:0];
            end else if (addr == OFS_CTRL) begin
                ctrl_next = {5'h00, wdata[2:0]};
            end
        end
        if (rd) begin
            if (addr == OFS_POLICY) begin
                rdata_next = {3'h0, policy_reg};
            end else if (addr == OFS_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (addr == OFS_STATUS) begin
                rdata_next = {2'h0, unit_src, ps.unit_present,
                    lost, hold_reg, alarm_reg};
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // Register stage for every group
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pp_reg <= '0;
            policy_reg <= POLICY_RESET;
            ctrl_reg <= CTRL_RESET;
            rdata <= 8'h00;
            hold_reg <= HOLD_NONE;
            mode_reg <= MODE_PANEL;
            alarm_reg <= 1'b0;
            outs <= '0;
        end else begin
            pp_reg <= ps;
            policy_reg <= policy_next;
            ctrl_reg <= ctrl_next;
            rdata <= rdata_next;
            hold_reg <= hold_next;
            mode_reg <= core.mode;
            alarm_reg <= alarm_next;
            outs <= outs_next;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_policy_legal_only: assert property (
        wr && addr == OFS_POLICY && !policy_legal(wdata[4:0])
        |=> $stable(policy_reg))
        else $error("illegal policy value was stored");

    a_reset_trip_gate: assert property (
        line_rst && trip_only && !core.tripped && !key_rst
        |=> !outs.reset_done)
        else $error("line reset accepted while not tripped");

    a_reset_coasts: assert property (
        reset_acc && core.running
        |=> outs.output_shutoff && outs.overload_clear)
        else $error("running reset did not shut off output");

    a_key_reset_trip: assert property (
        key_rst && !core.tripped && !line_rst |=> !outs.reset_done)
        else $error("panel reset key honoured without trip");

    a_loss_alarm_set: assert property (
        lost && detect_en |=> outs.panel_loss_alarm
        && outs.output_shutoff && outs.start_inhibit)
        else $error("panel loss did not raise alarm stop");

    a_no_loss_alarm: assert property (
        !loss_sel && !alarm_reg |=> !outs.panel_loss_alarm)
        else $error("alarm raised under continue policy");

    a_alarm_latched: assert property (
        alarm_reg && !reset_acc |=> outs.panel_loss_alarm)
        else $error("loss alarm dropped without reset");

    a_legacy_no_hold: assert property (
        !stop_any && hold_reg == HOLD_NONE && !$past(hold_set)
        |=> hold_reg == HOLD_NONE)
        else $error("hold entered under policy 0 to 3");

    a_ext_stop_holds: assert property (
        stop_any && core.mode == MODE_EXT && pstop
        && !alarm_reg && !(lost && detect_en)
        |=> outs.decel_stop && outs.panel_stop_hold
        && !outs.panel_loss_alarm)
        else $error("external stop did not hold");

    a_hold_blocks: assert property (
        hold_reg != HOLD_NONE |-> outs.start_inhibit)
        else $error("restart allowed during hold");

endmodule

// file: test/panel_terminal_model.sv
// Model of the built-in panel, detachable unit and start terminals.
// Assumes the bench sets levels in cmd and taps keys for one cycle.
`timescale 1ns/1ps
module panel_terminal_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire policy_pkg::pin_in_t cmd,
    output policy_pkg::pin_in_t pins
);
    import policy_pkg::*;
    localparam int PRESS = 6; // Key held down like a human press
    logic [4:0] req; // Key taps from the bench
    logic [4:0] last; // Taps seen one cycle ago
    int cnt [5]; // Cycles each key stays down
    assign req = {cmd.panel_stop_key, cmd.panel_reset_key,
        cmd.unit_stop_key, cmd.unit_reset_key, cmd.external_mode_key};
    // Stretch each tap into a press of several cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last <= '0;
            for (int i = 0; i < 5; i++)
                cnt[i] <= 0;
        end else begin
            last <= req;
            for (int i = 0; i < 5; i++) begin
                if (req[i] && !last[i])
                    cnt[i] <= PRESS;
                else if (cnt[i] != 0)
                    cnt[i] <= cnt[i] - 1;
            end
        end
    end
    // Levels pass through; an unplugged unit presses nothing
    always_comb begin
        pins = cmd;
        pins.panel_stop_key = cnt[4] != 0;
        pins.panel_reset_key = cnt[3] != 0;
        pins.unit_stop_key = cnt[2] != 0 && cmd.unit_present;
        pins.unit_reset_key = cnt[1] != 0 && cmd.unit_present;
        pins.external_mode_key = cnt[0] != 0;
    end
endmodule

// file: test/testbench.sv
// Self-checking bench for the reset, panel-loss and stop policy.
// Assumes a 200 MHz clock and a shortened panel-loss limit.
`timescale 1ns/1ps
module testbench;
    import policy_pkg::*;
    localparam int unsigned LIM = 20; // Shortened loss limit
    logic clk, arst_n, wr, rd; // Clock, reset, strobes
    logic [3:0] addr; // Register address
    logic [7:0] wdata, rdata, d; // Bus data and last read
    pin_in_t cmd, pins; // Bench wishes and model pins
    core_state_t core; // Drive core status
    policy_out_t outs; // Policy commands
    int err_count, n_checks; // Report counters
    int n_dec, n_done, n_shut, n_ovl; // Pulse counts
    // Policy writes: written value, value read back
    logic [15:0] wrows [12] = '{16'h0000, 16'h0303, 16'h0403,
        16'h0E0E, 16'h0D0E, 16'h1111, 16'h1211, 16'h3111,
        16'h0F0F, 16'h1010, 16'h1410, 16'h0101};
    // Reset gating: policy, tripped, source, accepted
    logic [19:0] rrows [12] = '{20'h0F050, 20'h0F151, 20'h0F060,
        20'h0F161, 20'h0E051, 20'h01050, 20'h03151, 20'h02051,
        20'h0E010, 20'h0E111, 20'h11030, 20'h11131};

    reset_panel_loss_stop_policy #(.LOSS_LIMIT(LIM))
        u_reset_panel_loss_stop_policy (.clk(clk), .arst_n(arst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pins(pins), .core(core), .outs(outs));
    panel_terminal_model u_panel_terminal_model (.clk(clk),
        .arst_n(arst_n), .cmd(cmd), .pins(pins));

    // Half-period toggle for 200 MHz
    always #2.5 clk = ~clk;
    // Count one-cycle pulses
    always @(posedge clk) begin
        if (outs.decel_stop === 1'b1) n_dec++;
        if (outs.reset_done === 1'b1) n_done++;
        if (outs.output_shutoff === 1'b1) n_shut++;
        if (outs.overload_clear === 1'b1) n_ovl++;
    end

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Zero pulse counts once the edge has landed
    task automatic clr;
        @(posedge clk);
        #1;
        n_dec = 0;
        n_done = 0;
        n_shut = 0;
        n_ovl = 0;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic set_key(input logic [2:0] k, input logic v);
        case (k)
            3'h0: cmd.panel_stop_key <= v;
            3'h1: cmd.panel_reset_key <= v;
            3'h2: cmd.unit_stop_key <= v;
            3'h3: cmd.unit_reset_key <= v;
            3'h4: cmd.external_mode_key <= v;
            3'h5: cmd.external_reset_input <= v;
            default: core.comm_reset <= v;
        endcase
    endtask
    // One-cycle tap, then time for sync and response
    task automatic tap(input logic [2:0] k);
        @(posedge clk);
        set_key(k, 1'b1);
        @(posedge clk);
        set_key(k, 1'b0);
        step(12);
    endtask

    // Cut a hang short
    initial begin
        #100000;
        err_count++;
        report_and_stop;
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        cmd = '0;
        core = '0;
        step(3);
        arst_n <= 1'b1;
        #1;
        check(outs, 32'h0);
        bus_rd(OFS_POLICY);
        check(d, 8'h0E);
        bus_rd(OFS_CTRL);
        check(d, 8'h02);
        bus_rd(4'hF);
        check(d, 8'h00);
        bus_wr(OFS_STATUS, 8'hFF);
        bus_rd(OFS_STATUS);
        check(d, 8'h00);
        core.running <= 1'b1;
        // Legal values stick, others leave the old one; running too
        for (int i = 0; i < 12; i++) begin
            bus_wr(OFS_POLICY, wrows[i][15:8]);
            bus_rd(OFS_POLICY);
            check(d, wrows[i][7:0]);
        end
        // Unit absent since reset never alarms
        bus_wr(OFS_POLICY, 8'h10);
        step(LIM + 20);
        check(outs.panel_loss_alarm, 1'b0);
        // Short absences restart the timer
        cmd.unit_present <= 1'b1;
        step(8);
        cmd.unit_present <= 1'b0;
        step(15);
        cmd.unit_present <= 1'b1;
        step(6);
        cmd.unit_present <= 1'b0;
        step(12);
        check(outs.panel_loss_alarm, 1'b0);
        step(20);
        check(outs.panel_loss_alarm, 1'b1);
        check(outs.output_shutoff, 1'b1);
        check(outs.start_inhibit, 1'b1);
        cmd.unit_present <= 1'b1;
        step(10);
        check(outs.panel_loss_alarm, 1'b1);
        clr;
        tap(5);
        check(outs.panel_loss_alarm, 1'b0);
        check(n_done, 1);
        // Continue policy during jog
        bus_wr(OFS_POLICY, 8'h0E);
        core.jog_active <= 1'b1;
        clr;
        cmd.unit_present <= 1'b0;
        step(LIM + 20);
        check(outs.panel_loss_alarm, 1'b0);
        check(n_dec, 1);
        core.jog_active <= 1'b0;
        cmd.unit_present <= 1'b1;
        // Serial link on the panel port
        bus_wr(OFS_POLICY, 8'h10);
        core.serial_on_panel_port <= 1'b1;
        step(8);
        cmd.unit_present <= 1'b0;
        step(LIM + 20);
        check(outs.panel_loss_alarm, 1'b0);
        core.mode <= MODE_PANEL;
        clr;
        tap(0);
        check(n_dec, 1);
        core.serial_on_panel_port <= 1'b0;
        cmd.unit_present <= 1'b1;
        step(8);
        // Reset acceptance by policy, trip and source
        for (int i = 0; i < 12; i++) begin
            bus_wr(OFS_POLICY, rrows[i][19:12]);
            core.tripped <= rrows[i][8];
            clr;
            tap(rrows[i][6:4]);
            check(n_done, rrows[i][3:0]);
            check(n_shut, rrows[i][3:0]);
            check(n_ovl, rrows[i][3:0]);
        end
        core.tripped <= 1'b0;
        // External-mode panel stop with coasting selected
        bus_wr(OFS_POLICY, 8'h0E);
        bus_wr(OFS_CTRL, 8'h03);
        core.mode <= MODE_EXT;
        cmd.forward_start_input <= 1'b1;
        clr;
        tap(0);
        check(n_dec, 1);
        check(n_shut, 0);
        check(outs.panel_stop_hold, 1'b1);
        check(outs.panel_loss_alarm, 1'b0);
        check(outs.start_inhibit, 1'b1);
        bus_rd(OFS_STATUS);
        check(d[2:1], 2'h1);
        // Operator clears through panel mode
        step(1);
        cmd.forward_start_input <= 1'b0;
        step(4);
        check(outs.panel_stop_hold, 1'b1);
        core.mode <= MODE_PANEL;
        step(4);
        check(outs.panel_stop_hold, 1'b0);
        core.mode <= MODE_EXT;
        cmd.forward_start_input <= 1'b1;
        step(4);
        check(outs.start_inhibit, 1'b0);
        // Unit stop cleared by the external-mode key
        tap(2);
        check(outs.panel_stop_hold, 1'b1);
        bus_rd(OFS_STATUS);
        check(d[2:1], 2'h2);
        step(1);
        cmd.forward_start_input <= 1'b0;
        tap(4);
        check(outs.panel_stop_hold, 1'b0);
        // Standard policy: stop only acts in panel mode
        bus_wr(OFS_POLICY, 8'h02);
        for (int m = 2; m >= 0; m--) begin
            core.mode <= op_mode_t'(m);
            clr;
            tap(0);
            check(n_dec, (m == 0) ? 1 : 0);
            check(outs.panel_stop_hold, 1'b0);
        end
        // Non-source panel stop in panel mode
        bus_wr(OFS_POLICY, 8'h0E);
        bus_wr(OFS_CTRL, 8'h02);
        bus_rd(OFS_STATUS);
        check(d[5], 1'b1);
        clr;
        tap(0);
        check(n_dec, 1);
        check(outs.panel_stop_hold, 1'b1);
        tap(5);
        check(outs.panel_stop_hold, 1'b0);
        // Unit-source hold survives a unit stop, cleared by entering external mode
        tap(0);
        check(outs.panel_stop_hold, 1'b1);
        tap(2);
        check(outs.panel_stop_hold, 1'b1);
        core.mode <= MODE_EXT;
        step(4);
        check(outs.panel_stop_hold, 1'b0);
        core.mode <= MODE_PANEL;
        step(4);
        check(outs.start_inhibit, 1'b0);
        bus_wr(OFS_CTRL, 8'h00);
        bus_rd(OFS_STATUS);
        check(d[5], 1'b0);
        // Power-cycle reset drops a hold and restores the default
        bus_wr(OFS_POLICY, 8'h11);
        core.mode <= MODE_EXT;
        tap(0);
        check(outs.panel_stop_hold, 1'b1);
        arst_n <= 1'b0;
        step(3);
        arst_n <= 1'b1;
        step(1);
        check(outs.panel_stop_hold, 1'b0);
        bus_rd(OFS_POLICY);
        check(d, 8'h0E);
        report_and_stop;
    end
endmodule
